/* File: pkg/mcls_pkg.sv */
package mcls_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOT_NS = 44400;
    localparam int SLOT_CYCLES = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOT_CNT_W = 10;
    localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYCLES - 1);

    // ************************************************************
    // channels
    // ************************************************************
    localparam int NUM_CH = 7;
    localparam int CH_W = 3;
    localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
    localparam logic [CH_W-1:0] CH_TEMP = 3'h6;
    localparam int ADC_W = 9;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MASK = 8'h02;
    localparam logic [7:0] ADDR_DAC = 8'h03;
    localparam logic [7:0] ADDR_TEMP_LSB = 8'h04;
    localparam logic [7:0] ADDR_VALUE_BASE = 8'h08;
    localparam logic [7:0] ADDR_HI_BASE = 8'h10;
    localparam logic [7:0] ADDR_LO_BASE = 8'h18;

    localparam int CFG_START_BIT = 0;
    localparam int CFG_INT_EN_BIT = 1;
    localparam int CFG_INT_CLR_BIT = 3;
    localparam int TEMP_LSB_BIT = 7;

    localparam logic [7:0] DAC_RESET = 8'hFF;
    localparam logic [7:0] HI_RESET = 8'hFF;
    localparam logic [7:0] LO_RESET = 8'h00;
    localparam logic [7:0] HOT_RESET = 8'h7F;
    localparam logic [7:0] HYST_RESET = 8'h7F;
    localparam logic [7:0] VALUE_RESET = 8'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;
endpackage

/* File: rtl/mcls_slot_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module mcls_slot_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic slot_done,
    output logic [mcls_pkg::CH_W-1:0] chan
);
    logic [mcls_pkg::SLOT_CNT_W-1:0] cnt;
    logic [mcls_pkg::SLOT_CNT_W-1:0] next_cnt;
    logic [mcls_pkg::CH_W-1:0] next_chan;
    wire last_chan = (chan == mcls_pkg::CH_TEMP);

    // one slot per channel, stopped timer parks on the first channel
    assign slot_done = run && (cnt == mcls_pkg::SLOT_LAST);
    assign next_cnt = !run ? '0 :
        (slot_done ? '0 : mcls_pkg::SLOT_CNT_W'(cnt + 1'b1));
    assign next_chan = !run ? mcls_pkg::CH_FIRST :
        (!slot_done ? chan :
        (last_chan ? mcls_pkg::CH_FIRST : mcls_pkg::CH_W'(chan + 1'b1)));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            chan <= mcls_pkg::CH_FIRST;
        end else begin
            cnt <= next_cnt;
            chan <= next_chan;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mcls_limit_check.sv */
`timescale 1ns/1ps
`default_nettype none
module mcls_limit_check (
    input wire logic is_temp,
    input wire logic [7:0] value,
    input wire logic [7:0] upper,
    input wire logic [7:0] lower,
    input wire logic hot_state,
    output logic out_of_limit,
    output logic next_hot
);
    // temperature is two's complement, voltages are unsigned
    wire above_hot = $signed(value) > $signed(upper);
    wire cooled = $signed(value) <= $signed(lower);
    wire volt_bad = (value > upper) || (value < lower);

    always_comb begin
        next_hot = hot_state;
        out_of_limit = 1'b0;
        if (is_temp) begin
            next_hot = hot_state ? !cooled : above_hot;
            out_of_limit = next_hot;
        end else begin
            out_of_limit = volt_bad;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mcls_top.sv */
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - each voltage channel has upper and lower limits; outside either flags
// - temperature flags above hot limit, releases only at or below hysteresis
// - start bit one with interrupt-clear bit zero begins the cycle
// - interrupt pin driven only while interrupt-enable bit is one
// - channels visited in fixed order, second core supply first, temp last
// - each finished conversion stored in its value register automatically
// - sequence repeats until start bit is written zero
// - slot lasts 44.4 us, seven slots per sequence
// - fan monitoring starts in the same cycle analog monitoring starts
// - fan sequence runs on its own after the common start
// - one unsigned 8-bit fan-control register drives the dac level
// - reset loads the fan-control register with FF
// - temperature compare uses the eight upper bits of nine
module mcls_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [mcls_pkg::CH_W-1:0] adc_chan,
    input wire logic [mcls_pkg::ADC_W-1:0] adc_result,
    output logic fan_start,
    output logic fan_run,
    output logic [7:0] dac_level,
    output logic irq,
    output logic int_pin_out,
    output logic int_pin_oe_n
);
    // ************************************************************
    // state
    // ************************************************************
    logic run;
    logic int_en;
    logic int_clr;
    logic temp_hot;
    logic temp_lsb;
    logic [6:0] status;
    logic [6:0] mask;
    logic [7:0] value_reg [mcls_pkg::NUM_CH];
    logic [7:0] hi_reg [mcls_pkg::NUM_CH];
    logic [7:0] lo_reg [mcls_pkg::NUM_CH];
    logic slot_done;
    logic out_of_limit;
    logic next_hot;
    logic next_run;
    logic [6:0] next_status;

    // ************************************************************
    // decode
    // ************************************************************
    wire wr_cfg = reg_wr && (reg_addr == mcls_pkg::ADDR_CFG);
    wire wr_status = reg_wr && (reg_addr == mcls_pkg::ADDR_STATUS);
    wire wr_mask = reg_wr && (reg_addr == mcls_pkg::ADDR_MASK);
    wire wr_dac = reg_wr && (reg_addr == mcls_pkg::ADDR_DAC);
    wire in_value = (reg_addr >= mcls_pkg::ADDR_VALUE_BASE) &&
        (reg_addr < mcls_pkg::ADDR_VALUE_BASE + 8'(mcls_pkg::NUM_CH));
    wire in_hi = (reg_addr >= mcls_pkg::ADDR_HI_BASE) &&
        (reg_addr < mcls_pkg::ADDR_HI_BASE + 8'(mcls_pkg::NUM_CH));
    wire in_lo = (reg_addr >= mcls_pkg::ADDR_LO_BASE) &&
        (reg_addr < mcls_pkg::ADDR_LO_BASE + 8'(mcls_pkg::NUM_CH));
    wire [mcls_pkg::CH_W-1:0] idx = reg_addr[mcls_pkg::CH_W-1:0];
    wire start_req = reg_wdata[mcls_pkg::CFG_START_BIT];
    wire clr_req = reg_wdata[mcls_pkg::CFG_INT_CLR_BIT];
    wire is_temp = (adc_chan == mcls_pkg::CH_TEMP);
    wire [7:0] adc_msb = adc_result[mcls_pkg::ADC_W-1:1];

    // ************************************************************
    // sequencer
    // ************************************************************
    mcls_slot_timer u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(run),
        .slot_done(slot_done),
        .chan(adc_chan)
    );

    // a start with interrupt-clear set leaves the run state unchanged
    assign next_run = !wr_cfg ? run :
        (!start_req ? 1'b0 : (clr_req ? run : 1'b1));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 1'b0;
            int_en <= 1'b0;
            int_clr <= 1'b0;
            fan_start <= 1'b0;
        end else begin
            run <= next_run;
            fan_start <= next_run && !run;
            if (wr_cfg) begin
                int_en <= reg_wdata[mcls_pkg::CFG_INT_EN_BIT];
                int_clr <= clr_req;
            end
        end
    end

    // fan logic only sees start and run; no later handshake ties them
    assign fan_run = run;

    // ************************************************************
    // values and limits
    // ************************************************************
    mcls_limit_check u_check (
        .is_temp(is_temp),
        .value(adc_msb),
        .upper(hi_reg[adc_chan]),
        .lower(lo_reg[adc_chan]),
        .hot_state(temp_hot),
        .out_of_limit(out_of_limit),
        .next_hot(next_hot)
    );

    genvar g;
    generate
        for (g = 0; g < mcls_pkg::NUM_CH; g++) begin : g_ch
            wire hit = slot_done && (adc_chan == mcls_pkg::CH_W'(g));
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    value_reg[g] <= mcls_pkg::VALUE_RESET;
                    hi_reg[g] <= (g == mcls_pkg::NUM_CH - 1) ?
                        mcls_pkg::HOT_RESET : mcls_pkg::HI_RESET;
                    lo_reg[g] <= (g == mcls_pkg::NUM_CH - 1) ?
                        mcls_pkg::HYST_RESET : mcls_pkg::LO_RESET;
                end else begin
                    if (hit) begin
                        value_reg[g] <= adc_msb;
                    end
                    if (reg_wr && in_hi && idx == mcls_pkg::CH_W'(g)) begin
                        hi_reg[g] <= reg_wdata;
                    end
                    if (reg_wr && in_lo && idx == mcls_pkg::CH_W'(g)) begin
                        lo_reg[g] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_hot <= 1'b0;
            temp_lsb <= 1'b0;
        end else if (slot_done && is_temp) begin
            temp_hot <= next_hot;
            temp_lsb <= adc_result[0];
        end
    end

    // ************************************************************
    // interrupt
    // ************************************************************
    // an event is only raised by a finished conversion
    wire [6:0] set_bits = (slot_done && out_of_limit) ?
        7'(1 << adc_chan) : 7'h00;
    wire [6:0] clr_bits = (wr_cfg && clr_req) ? 7'h7F :
        (wr_status ? reg_wdata[6:0] : 7'h00);
    // set beats clear so a same-cycle event is never lost
    assign next_status = (status & ~clr_bits) | set_bits;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 7'h00;
            mask <= mcls_pkg::MASK_RESET;
            dac_level <= mcls_pkg::DAC_RESET;
        end else begin
            status <= next_status;
            if (wr_mask) begin
                mask <= reg_wdata[6:0];
            end
            if (wr_dac) begin
                dac_level <= reg_wdata;
            end
        end
    end

    assign irq = |(status & mask);
    // pin is active low and open drain; clear bit holds it released
    assign int_pin_out = 1'b0;
    assign int_pin_oe_n = !(irq && int_en && !int_clr);

    // ************************************************************
    // register read
    // ************************************************************
    wire [7:0] cfg_rd = {4'h0, int_clr, 1'b0, int_en, run};
    wire [7:0] rd_mux =
        (reg_addr == mcls_pkg::ADDR_CFG) ? cfg_rd :
        (reg_addr == mcls_pkg::ADDR_STATUS) ? {1'b0, status} :
        (reg_addr == mcls_pkg::ADDR_MASK) ? {1'b0, mask} :
        (reg_addr == mcls_pkg::ADDR_DAC) ? dac_level :
        (reg_addr == mcls_pkg::ADDR_TEMP_LSB) ? {temp_lsb, 7'h00} :
        in_value ? value_reg[idx] :
        in_hi ? hi_reg[idx] :
        in_lo ? lo_reg[idx] : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [mcls_pkg::SLOT_CNT_W-1:0] since_slot;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_slot <= '0;
        end else begin
            since_slot <= (!run || slot_done) ? '0 :
                mcls_pkg::SLOT_CNT_W'(since_slot + 1'b1);
        end
    end

    volt_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slot_done && !is_temp &&
        (adc_msb > hi_reg[adc_chan] || adc_msb < lo_reg[adc_chan])
        |=> status[$past(adc_chan)])
        else $error("voltage excursion not flagged");
    temp_hyst_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slot_done && is_temp && temp_hot &&
        $signed(adc_msb) > $signed(lo_reg[mcls_pkg::CH_TEMP])
        |=> temp_hot)
        else $error("hot flag released above hysteresis");
    start_cfg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_cfg && start_req && !clr_req |=> run)
        else $error("start write did not run");
    int_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !int_en |-> int_pin_oe_n)
        else $error("pin driven while disabled");
    chan_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slot_done && next_run |=> adc_chan == (($past(adc_chan) ==
        mcls_pkg::CH_TEMP) ? mcls_pkg::CH_FIRST : $past(adc_chan) + 3'h1))
        else $error("channel order broken");
    value_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slot_done |=> value_reg[$past(adc_chan)] == $past(adc_msb))
        else $error("value not stored");
    stop_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run && !(wr_cfg && !start_req) |=> run)
        else $error("sequence stopped on its own");
    slot_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slot_done |-> since_slot == mcls_pkg::SLOT_LAST)
        else $error("slot length wrong");
    fan_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(run) |-> fan_start ##1 !fan_start)
        else $error("fan start not with analog start");
    dac_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wr_dac |=> $stable(dac_level))
        else $error("dac level changed without write");
    dac_reset_a: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> dac_level == mcls_pkg::DAC_RESET)
        else $error("dac not full scale after reset");

    wrap_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        slot_done && is_temp ##1 adc_chan == mcls_pkg::CH_FIRST);
    hot_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(temp_hot));
    pin_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(int_pin_oe_n));
    stop_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(run));
endmodule
`default_nettype wire

/* File: testbench/mcls_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// converter model: one 9-bit result per mux channel
// ************************************************************
module mcls_conv_model (
    input wire logic ref_clk,
    input wire logic [mcls_pkg::CH_W-1:0] adc_chan,
    input wire logic [6:0][8:0] levels,
    output logic [mcls_pkg::ADC_W-1:0] adc_result
);
    // one clock of lag after a mux change, so the design must not
    // sample in the first cycle of a slot
    always_ff @(posedge ref_clk) begin
        adc_result <= levels[adc_chan];
    end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk, rst_n, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dac_level;
    logic [mcls_pkg::CH_W-1:0] adc_chan, cur;
    logic [mcls_pkg::ADC_W-1:0] adc_result;
    logic fan_start, fan_run, irq, int_pin_out, int_pin_oe_n;
    logic [6:0][8:0] levels;
    int bad_count, tests_run, n;

    mcls_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_chan(adc_chan), .adc_result(adc_result),
        .fan_start(fan_start), .fan_run(fan_run), .dac_level(dac_level),
        .irq(irq), .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n));
    mcls_conv_model conv_u (.ref_clk(ref_clk), .adc_chan(adc_chan),
        .levels(levels), .adc_result(adc_result));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // access and check tasks
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(exp));
    endtask
    task automatic wait_seq();
        repeat (7 * 888 + 8) @(posedge ref_clk);
    endtask
    // settle first so no old-value sample lands after the clear
    task automatic step(input logic [8:0] t);
        levels[6] <= t;
        repeat (4) @(posedge ref_clk);
        wr(mcls_pkg::ADDR_STATUS, 8'h7F);
        wait_seq();
    endtask
    task automatic close_out();
        $display("mismatches %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard, well beyond about 40k cycles of tests
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        close_out();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        levels = '0;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk(16'(dac_level), 16'h00FF);
        chk(16'(fan_run), 16'h0000);
        rc(mcls_pkg::ADDR_DAC, 8'hFF);
        wr(mcls_pkg::ADDR_DAC, 8'h5A);
        rc(mcls_pkg::ADDR_DAC, 8'h5A);
        chk(16'(dac_level), 16'h005A);
        wr(mcls_pkg::ADDR_HI_BASE, 8'h80);
        wr(mcls_pkg::ADDR_LO_BASE + 8'h01, 8'h10);
        wr(mcls_pkg::ADDR_HI_BASE + 8'h06, 8'h30);
        wr(mcls_pkg::ADDR_LO_BASE + 8'h06, 8'h20);
        wr(mcls_pkg::ADDR_MASK, 8'h7F);
        // voltages take the upper eight bits of the converter word too
        levels <= {9'h0C1, 9'h045, 9'h044, 9'h043, 9'h042, 9'h005, 9'h120};
        wr(mcls_pkg::ADDR_CFG, 8'h03);
        // fan start stands for one cycle only, so look at it right away
        #1;
        chk(16'(fan_start), 16'h0001);
        chk(16'(fan_run), 16'h0001);
        @(posedge ref_clk);
        #1;
        chk(16'(fan_start), 16'h0000);
        for (int k = 1; k < 14; k++) begin
            n = 0;
            cur = adc_chan;
            while (adc_chan === cur && n < 1000) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            chk(16'(adc_chan), 16'(k % 7));
            if (k > 1) chk(16'(n), 16'(44400 / 50));
            chk(16'(fan_run), 16'h0001);
        end
        for (int i = 0; i < 6; i++) begin
            rc(mcls_pkg::ADDR_VALUE_BASE + 8'(i), levels[i][8:1]);
        end
        rc(mcls_pkg::ADDR_VALUE_BASE + 8'h06, 8'h60);
        rc(mcls_pkg::ADDR_TEMP_LSB, 8'h80);
        rc(mcls_pkg::ADDR_STATUS, 8'h43);
        chk(16'(int_pin_oe_n), 16'h0000);
        // hysteresis walk: between limits, negative, between, above
        levels[0] <= 9'h050;
        levels[1] <= 9'h050;
        step(9'h050);
        rc(mcls_pkg::ADDR_STATUS, 8'h40);
        step(9'h1F0);
        rc(mcls_pkg::ADDR_STATUS, 8'h00);
        step(9'h050);
        rc(mcls_pkg::ADDR_STATUS, 8'h00);
        step(9'h062);
        rc(mcls_pkg::ADDR_STATUS, 8'h40);
        wr(mcls_pkg::ADDR_CFG, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(16'(fan_run), 16'h0000);
        chk(16'(adc_chan), 16'h0000);
        chk(16'(irq), 16'h0001);
        chk(16'(int_pin_oe_n), 16'h0001);
        levels[2] <= 9'h0AA;
        repeat (1800) @(posedge ref_clk);
        rc(mcls_pkg::ADDR_VALUE_BASE + 8'h02, 8'h21);
        wr(mcls_pkg::ADDR_CFG, 8'h02);
        #1;
        chk(16'(int_pin_oe_n), 16'h0000);
        chk(16'(int_pin_out), 16'h0000);
        wr(mcls_pkg::ADDR_CFG, 8'h0B);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(16'(fan_run), 16'h0000);
        chk(16'(int_pin_oe_n), 16'h0001);
        rc(mcls_pkg::ADDR_STATUS, 8'h00);
        wr(mcls_pkg::ADDR_VALUE_BASE, 8'hAA);
        rc(mcls_pkg::ADDR_VALUE_BASE, 8'h28);
        rc(8'h3F, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
